// ==== hw/wdit_counter.sv ====
// Purpose: overflow counter of the watchdog, 128 prescaled ticks per period
// Assumes: tick is a one-cycle pulse from the prescaler
// Notes:   clear beats tick; overflow is combinational for the caller to register
`timescale 1ns/1ps
`default_nettype none
module wdit_counter
  import wdit_pkg::*;
#(
  parameter int CW = wdit_pkg::CNT_W
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          clear,
  input  wire logic          tick,
  output logic [CW-1:0]      count,
  output logic               overflow
);

  logic [CW-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign count    = cnt_q;
  assign overflow = tick & (&cnt_q) & ~clear;

  AST_OVF_ON_LAST_TICK: assert property (@(posedge pclk) disable iff (!presetn)
    overflow |=> (cnt_q == '0))
    else $error("counter did not wrap to zero on overflow");

endmodule // wdit_counter
`default_nettype wire

// ==== hw/wdit_pkg.sv ====
// Purpose: shared constants and types of the watchdog / interval timer
// Assumes: APB with 32-bit data, registers one aligned word each
// Notes:   printed offsets are register indices; byte address is four times the index
package wdit_pkg;

  // bus geometry
  localparam int              ADDR_W      = 20;
  localparam int              DATA_W      = 32;

  // printed register indices and their byte addresses
  localparam logic [15:0]     CS_INDEX    = 16'hff42;
  localparam logic [15:0]     MODE_INDEX  = 16'hfff9;
  localparam logic [ADDR_W-1:0] CS_ADDR   = {2'h0, CS_INDEX, 2'h0};
  localparam logic [ADDR_W-1:0] MODE_ADDR = {2'h0, MODE_INDEX, 2'h0};

  // event and readback registers
  localparam logic [ADDR_W-1:0] STAT_ADDR = 20'h00000;
  localparam logic [ADDR_W-1:0] IEN_ADDR  = 20'h00004;
  localparam logic [ADDR_W-1:0] ICLR_ADDR = 20'h00008;
  localparam logic [ADDR_W-1:0] CNT_ADDR  = 20'h0000c;

  // field positions
  localparam int              CS_W        = 3;
  localparam int              MODE_RUN    = 7;
  localparam int              MODE_HI     = 4;
  localparam int              MODE_LO     = 3;

  // reset values
  localparam logic [CS_W-1:0] CS_RESET    = 3'h0;
  localparam logic            MODE_RESET  = 1'h0;
  localparam logic [2:0]      EV_RESET_V  = 3'h0;

  // timing: prescaler taps fx/16..fx/1024, 128 ticks to overflow
  localparam int              PRE_W       = 10;
  localparam int              CNT_W       = 7;
  localparam int              TAP_BASE    = 4;
  localparam int              TAP_STEP    = 2;

  // event bit positions
  localparam int              EV_W        = 3;
  localparam int              EV_INTERVAL = 0;
  localparam int              EV_NMI      = 1;
  localparam int              EV_SYSRST   = 2;

  typedef enum logic [3:0] {
    WDIT_MODE_STOP     = 4'b0001,
    WDIT_MODE_INTERVAL = 4'b0010,
    WDIT_MODE_NMI      = 4'b0100,
    WDIT_MODE_RESET    = 4'b1000
  } wdit_mode_t;

  typedef enum logic [1:0] {
    WDIT_BUS_IDLE = 2'b01,
    WDIT_BUS_ACK  = 2'b10
  } wdit_bus_t;

endpackage

// ==== hw/wdit_prescaler.sv ====
// Purpose: main-clock prescaler with four selectable taps, counting only while enable is high
// Assumes: pclk is the main system clock
// Notes:   never cleared by a restart, only by reset
`timescale 1ns/1ps
`default_nettype none
module wdit_prescaler
  import wdit_pkg::*;
#(
  parameter int PW = wdit_pkg::PRE_W
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic [1:0] sel,
  output logic            tick
);

  logic [PW-1:0] pre_q;
  logic [3:0]    hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (enable) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // tap g fires once every 2^(4+2g) clocks: fx/16, /64, /256, /1024
  genvar g;
  for (g = 0; g < 4; g++) begin : g_tap
    assign hit[g] = &pre_q[TAP_BASE + TAP_STEP*g - 1:0];
  end

  assign tick = enable & hit[sel];

endmodule // wdit_prescaler
`default_nettype wire

// ==== hw/wdit_top.sv ====
// Purpose: watchdog timer that doubles as interval timer, APB register slave
// Assumes: pclk is the main system clock; power-mode inputs are pclk-synchronous
// Notes:   interrupt controller, cpu clock select and reset generator sit outside
`timescale 1ns/1ps
`default_nettype none
// How it works
// - clock select picks fx/16, /64, /256, /1024; other codes are prohibited.
// - mode register takes bit or byte writes, reset clears it.
// - reset clears clock select, giving the shortest period.
// - writing run clears the counter and restarts; run low keeps it stopped.
// - once run is set, writes of zero are ignored until reset.
// - mode 00 stop, 01 interval irq, 10 nmi, 11 system reset.
// - each mode bit sticks at one until reset.
// - watchdog overflow gives system reset if low mode bit, else nmi.
// - interval mode raises the maskable interval interrupt on every overflow.
// - counting continues in halt and stops in stop mode.
// - no counting while the cpu runs from the subsystem clock.
// - restart clears the counter only, the prescaler keeps running.
// - selecting watchdog with overflow request flag set raises nmi at once.
module wdit_top
  import wdit_pkg::*;
(
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [wdit_pkg::ADDR_W-1:0] paddr,
  input  wire logic [wdit_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [wdit_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      stop_mode,
  input  wire logic                      cpu_on_subclock,
  input  wire logic                      overflow_request_flag,
  input  wire logic                      interval_interrupt_mask,
  output logic                           interval_interrupt,
  output logic                           nmi_request,
  output logic                           system_reset_request,
  output logic                           irq
);

  // bus side
  wdit_bus_t             bus_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [DATA_W-1:0]     prdata_q;
  logic                  access;
  logic                  done;
  logic                  prep;
  logic                  wr;
  logic                  lane0;
  logic                  hit_cs;
  logic                  hit_mode;
  logic                  hit_stat;
  logic                  hit_ien;
  logic                  hit_iclr;
  logic                  hit_cnt;
  logic                  mapped;
  logic [DATA_W-1:0]     rdata_d;

  // control registers
  logic [CS_W-1:0]       cs_q;
  logic                  run_q;
  logic                  mode_high_bit_q;
  logic                  mode_low_bit_q;
  logic                  wr_mode;
  logic                  restart;
  wdit_mode_t            mode;

  // counting
  logic                  count_en;
  logic                  tick;
  logic [CNT_W-1:0]      count;
  logic                  ovf_raw;
  logic                  ovf;

  // events and interrupt
  logic                  ev_interval;
  logic                  ev_nmi;
  logic                  ev_sysrst;
  logic                  nmi_on_select;
  logic [EV_W-1:0]       ev_vec;
  logic [EV_W-1:0]       clr_vec;
  logic [EV_W-1:0]       stat_q;
  logic [EV_W-1:0]       ien_q;
  logic                  irq_q;
  logic                  interval_interrupt_q;
  logic                  nmi_request_q;
  logic                  system_reset_request_q;

  assign access = psel & penable;
  assign done   = access & pready_q;
  assign prep   = access & ~pready_q;
  assign wr     = done & pwrite;
  // byte-wide registers live in lane 0; writes without it are dropped
  assign lane0  = pstrb[0];

  always_comb begin
    hit_cs   = (paddr == CS_ADDR);
    hit_mode = (paddr == MODE_ADDR);
    hit_stat = (paddr == STAT_ADDR);
    hit_ien  = (paddr == IEN_ADDR);
    hit_iclr = (paddr == ICLR_ADDR);
    hit_cnt  = (paddr == CNT_ADDR);
    mapped   = hit_cs | hit_mode | hit_stat | hit_ien | hit_iclr | hit_cnt;
  end

  // unmapped and reserved bits read as zero
  always_comb begin
    rdata_d = '0;
    if (hit_cs) begin
      rdata_d[CS_W-1:0] = cs_q;
    end else if (hit_mode) begin
      rdata_d[MODE_RUN] = run_q;
      rdata_d[MODE_HI]  = mode_high_bit_q;
      rdata_d[MODE_LO]  = mode_low_bit_q;
    end else if (hit_stat) begin
      rdata_d[EV_W-1:0] = stat_q;
    end else if (hit_ien) begin
      rdata_d[EV_W-1:0] = ien_q;
    end else if (hit_cnt) begin
      rdata_d[CNT_W-1:0] = count;
    end
  end

  // one wait state: data is prepared in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q     <= WDIT_BUS_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      case (bus_q)
        WDIT_BUS_IDLE: begin
          if (prep) begin
            bus_q     <= WDIT_BUS_ACK;
            pready_q  <= 1'b1;
            pslverr_q <= ~mapped;
            prdata_q  <= pwrite ? '0 : rdata_d;
          end
        end
        WDIT_BUS_ACK: begin
          bus_q     <= WDIT_BUS_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          bus_q     <= WDIT_BUS_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  // clock select: prohibited codes are stored, only bits 2:1 steer the tap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_q <= CS_RESET;
    end else if (wr && hit_cs && lane0) begin
      cs_q <= pwdata[CS_W-1:0];
    end
  end

  // mode register: a bit write is a byte write of the read-back value,
  // which the sticky bits make harmless
  assign wr_mode = wr & hit_mode & lane0;
  assign restart = wr_mode & pwdata[MODE_RUN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q           <= MODE_RESET;
      mode_high_bit_q <= MODE_RESET;
      mode_low_bit_q  <= MODE_RESET;
    end else if (wr_mode) begin
      run_q           <= run_q | pwdata[MODE_RUN];
      mode_high_bit_q <= mode_high_bit_q | pwdata[MODE_HI];
      mode_low_bit_q  <= mode_low_bit_q | pwdata[MODE_LO];
    end
  end

  always_comb begin
    case ({mode_high_bit_q, mode_low_bit_q})
      2'b00:   mode = WDIT_MODE_STOP;
      2'b01:   mode = WDIT_MODE_INTERVAL;
      2'b10:   mode = WDIT_MODE_NMI;
      2'b11:   mode = WDIT_MODE_RESET;
      default: mode = WDIT_MODE_STOP;
    endcase
  end

  // halt is not an input: the count simply keeps going through it
  assign count_en = run_q & (mode != WDIT_MODE_STOP)
                  & ~stop_mode
                  & ~cpu_on_subclock;

  wdit_prescaler #(
    .PW (PRE_W)
  ) u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (count_en),
    .sel     (cs_q[2:1]),
    .tick    (tick)
  );

  wdit_counter #(
    .CW (CNT_W)
  ) u_counter (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (restart),
    .tick     (tick),
    .count    (count),
    .overflow (ovf_raw)
  );

  // a refresh in the overflow cycle wins over the overflow
  assign ovf = ovf_raw & ~restart;

  // flag is owned by the interrupt controller; sampled here as it stands
  assign nmi_on_select = wr_mode & pwdata[MODE_HI] & ~mode_high_bit_q
                       & overflow_request_flag;

  always_comb begin
    ev_interval = ovf & (mode == WDIT_MODE_INTERVAL);
    ev_nmi      = (ovf & (mode == WDIT_MODE_NMI)) | nmi_on_select;
    ev_sysrst   = ovf & (mode == WDIT_MODE_RESET);
    ev_vec      = '0;
    ev_vec[EV_INTERVAL] = ev_interval;
    ev_vec[EV_NMI]      = ev_nmi;
    ev_vec[EV_SYSRST]   = ev_sysrst;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_interrupt_q   <= 1'b0;
      nmi_request_q          <= 1'b0;
      system_reset_request_q <= 1'b0;
    end else begin
      interval_interrupt_q   <= ev_interval & ~interval_interrupt_mask;
      nmi_request_q          <= ev_nmi;
      system_reset_request_q <= ev_sysrst;
    end
  end

  // sticky status, set beats clear in the same cycle
  assign clr_vec = (wr && hit_iclr && lane0) ? pwdata[EV_W-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= EV_RESET_V;
      ien_q  <= EV_RESET_V;
    end else begin
      stat_q <= (stat_q & ~clr_vec) | ev_vec;
      if (wr && hit_ien && lane0) begin
        ien_q <= pwdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & ien_q);
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign interval_interrupt   = interval_interrupt_q;
  assign nmi_request          = nmi_request_q;
  assign system_reset_request = system_reset_request_q;
  assign irq                  = irq_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RUN_STICKY: assert property (run_q |=> run_q)
    else $error("run bit fell without reset");

  AST_MODE_HI_STICKY: assert property (mode_high_bit_q |=> mode_high_bit_q)
    else $error("high mode bit fell without reset");

  AST_MODE_LO_STICKY: assert property (mode_low_bit_q |=> mode_low_bit_q)
    else $error("low mode bit fell without reset");

  AST_RESTART_CLEARS: assert property (restart |=> count == '0)
    else $error("restart did not clear the counter");

  AST_IDLE_WHEN_NOT_RUN: assert property (!run_q |=> $stable(count))
    else $error("counter moved while not running");

  AST_FROZEN_IN_STOP: assert property (
    (stop_mode || cpu_on_subclock) && !restart |=> $stable(count))
    else $error("counter moved in stop or on subsystem clock");

  AST_NMI_ON_OVF: assert property (
    ovf && mode == WDIT_MODE_NMI |=> nmi_request && !system_reset_request)
    else $error("watchdog mode 1 overflow without nmi");

  AST_RESET_ON_OVF: assert property (
    ovf && mode == WDIT_MODE_RESET |=> system_reset_request && !nmi_request)
    else $error("watchdog mode 2 overflow without reset request");

  AST_INTERVAL_IRQ: assert property (
    ovf && mode == WDIT_MODE_INTERVAL && !interval_interrupt_mask |=> interval_interrupt)
    else $error("interval overflow without interrupt");

  AST_NMI_ON_SELECT: assert property (nmi_on_select |=> nmi_request && stat_q[EV_NMI])
    else $error("watchdog select with flag set gave no nmi");

  AST_READ_UPPER_ZERO: assert property (pready_q |-> prdata_q[DATA_W-1:8] == '0)
    else $error("reserved read bits not zero");

  AST_CS_RESET_SHORT: assert property ($rose(presetn) |-> cs_q == CS_RESET)
    else $error("clock select not cleared by reset");

  AST_MASK_BLOCKS_INTERVAL: assert property (
    interval_interrupt_mask |=> !interval_interrupt)
    else $error("masked interval interrupt reached the output");

  AST_STATUS_SET_WINS: assert property (
    (|ev_vec) |=> (stat_q & $past(ev_vec)) == $past(ev_vec))
    else $error("event did not set its status bit");

  AST_UNMAPPED_READ_ZERO: assert property (
    prep && !mapped |=> pslverr_q && prdata_q == '0)
    else $error("unmapped access not refused");

  AST_PREADY_ONE_CYCLE: assert property (pready_q |=> !pready_q)
    else $error("ready stood longer than one cycle");

endmodule // wdit_top
`default_nettype wire

// ==== sim/tb_watchdog_interval_timer.sv ====
// Purpose: self-checking bench of the watchdog / interval timer over APB
// Assumes: one wait state answer, fx/16 after reset, power-mode inputs on pclk
// Notes:   expectations come from an integer model of the two control registers
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_interval_timer;
  import wdit_pkg::*;
  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [3:0]        pstrb;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              stop_mode;
  logic              cpu_on_subclock;
  logic              ovf_flag;
  logic              int_mask;
  logic              interval_interrupt;
  logic              nmi_request;
  logic              system_reset_request;
  logic              irq;
  wire  [2:0]        ev = {system_reset_request, nmi_request, interval_interrupt};
  int                mismatches;
  int                n_checks;
  int                seed;
  int                m_cs;
  int                m_mode;
  int                cyc;
  int                c0;
  logic [DATA_W-1:0] rd;
  logic              err;

  wdit_top dut (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .psel                    (psel),
    .penable                 (penable),
    .pwrite                  (pwrite),
    .paddr                   (paddr),
    .pwdata                  (pwdata),
    .pstrb                   (pstrb),
    .prdata                  (prdata),
    .pready                  (pready),
    .pslverr                 (pslverr),
    .stop_mode               (stop_mode),
    .cpu_on_subclock         (cpu_on_subclock),
    .overflow_request_flag   (ovf_flag),
    .interval_interrupt_mask (int_mask),
    .interval_interrupt      (interval_interrupt),
    .nmi_request             (nmi_request),
    .system_reset_request    (system_reset_request),
    .irq                     (irq)
  );

  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until pready is sampled high; the task fixes no latency here
  task automatic apb(input logic is_wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      check("pready wait", 32'h1, 32'h0);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // model: clock select keeps three bits, mode bits and run only ever set
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    apb(1'b1, a, d);
    if (a == CS_ADDR) begin
      m_cs = d & 32'h7;
    end
    if (a == MODE_ADDR) begin
      m_mode = m_mode | (d & 32'h98);
    end
  endtask

  task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    check(what, exp, rd);
  endtask

  // bit0 of clock select is a prohibited choice and is not part of the divider
  function automatic int period();
    return 128 * (16 << (2 * (m_cs >> 1)));
  endfunction

  task automatic wait_ev(input int k, input int lim);
    cyc = 0;
    do begin
      @(posedge pclk);
      cyc++;
    end while (ev[k] !== 1'b1 && cyc < lim);
  endtask

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    m_cs = 0;
    m_mode = 0;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    final_report();
  end

  initial begin
    seed = 52504;
    mismatches = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    stop_mode = 1'b0;
    cpu_on_subclock = 1'b0;
    ovf_flag = 1'b0;
    int_mask = 1'b0;
    do_reset();
    rchk("clock select reset", CS_ADDR, 32'h0);
    rchk("mode reset", MODE_ADDR, 32'h0);
    rchk("status reset", STAT_ADDR, 32'h0);
    rchk("count reset", CNT_ADDR, 32'h0);
    rchk("unmapped read", 20'h00040, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    repeat (6) begin
      wr(CS_ADDR, $random(seed));
      rchk("clock select readback", CS_ADDR, m_cs);
    end
    // a write that leaves lane 0 out must not reach the byte register
    pstrb <= 4'he;
    apb(1'b1, CS_ADDR, 32'h7 & ~m_cs);
    pstrb <= 4'hf;
    rchk("write without lane 0", CS_ADDR, m_cs);
    $display("test reset and registers done");
    wr(CS_ADDR, 32'h0);
    wr(MODE_ADDR, 32'h80);
    repeat (300) @(posedge pclk);
    rchk("count in mode stop", CNT_ADDR, 32'h0);
    wr(MODE_ADDR, 32'h00);
    rchk("run sticky", MODE_ADDR, m_mode);
    wr(IEN_ADDR, 32'h1);
    wr(MODE_ADDR, 32'hff08);
    rchk("mode unused bits", MODE_ADDR, m_mode);
    wait_ev(EV_INTERVAL, 3000);
    wait_ev(EV_INTERVAL, 3000);
    check("interval period", period(), cyc);
    repeat (2) @(posedge pclk);
    check("irq after interval", 32'h1, {31'h0, irq});
    rchk("status interval", STAT_ADDR, 32'h1);
    wr(ICLR_ADDR, 32'h1);
    rchk("status cleared", STAT_ADDR, 32'h0);
    check("irq cleared", 32'h0, {31'h0, irq});
    wr(MODE_ADDR, 32'h00);
    rchk("mode bits sticky", MODE_ADDR, 32'h88);
    $display("test interval done");
    for (int k = 0; k < 2; k++) begin
      wr(MODE_ADDR, 32'h80);
      stop_mode <= (k == 0);
      cpu_on_subclock <= (k == 1);
      repeat (4) @(posedge pclk);
      apb(1'b0, CNT_ADDR, '0);
      c0 = rd;
      repeat (400) @(posedge pclk);
      rchk("count frozen", CNT_ADDR, c0);
      stop_mode <= 1'b0;
      cpu_on_subclock <= 1'b0;
    end
    $display("test freeze done");
    wr(MODE_ADDR, 32'h80);
    wait_ev(EV_INTERVAL, 3000);
    check("restart period", 32'h1, {31'h0, cyc >= period() - 16 && cyc <= period() + 2});
    int_mask <= 1'b1;
    wait_ev(EV_INTERVAL, period() + 50);
    check("masked interval", period() + 50, cyc);
    int_mask <= 1'b0;
    wr(CS_ADDR, 32'h2);
    wait_ev(EV_INTERVAL, 9000);
    wait_ev(EV_INTERVAL, 9000);
    check("interval period fx/64", period(), cyc);
    $display("test restart and select done");
    do_reset();
    wr(IEN_ADDR, 32'h2);
    wr(MODE_ADDR, 32'h90);
    repeat (3) begin
      wait_ev(EV_NMI, 1500);
      check("no nmi while refreshed", 32'd1500, cyc);
      wr(MODE_ADDR, 32'h90);
    end
    wait_ev(EV_NMI, 2200);
    check("nmi on overflow", 32'h1, {31'h0, cyc >= period() - 16 && cyc <= period() + 2});
    repeat (2) @(posedge pclk);
    check("irq after nmi", 32'h1, {31'h0, irq});
    wr(MODE_ADDR, 32'h08);
    rchk("no return to interval", MODE_ADDR, 32'h98);
    wait_ev(EV_SYSRST, period() + 100);
    check("system reset on overflow", 32'h1, {31'h0, cyc < period() + 100});
    $display("test watchdog done");
    do_reset();
    ovf_flag <= 1'b1;
    wr(MODE_ADDR, 32'h10);
    wait_ev(EV_NMI, 8);
    check("nmi on select", 32'h1, {31'h0, cyc <= 3});
    ovf_flag <= 1'b0;
    $display("test nmi on select done");
    final_report();
  end
endmodule // tb_watchdog_interval_timer
`default_nettype wire
